// ---- dchan_defines.svh ----
`ifndef DCHAN_DEFINES_SVH
`define DCHAN_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MAIN_STATUS   6'h00
`define OFS_MAIN_DISABLE  6'h04
`define OFS_EXT_STATUS    6'h08
`define OFS_CODE_RX_0     6'h0c
`define OFS_CODE_RX_1     6'h10
`define OFS_FEATURE_1     6'h14
`define OFS_MON_CTRL      6'h18
`define OFS_MON_STATUS    6'h1c
`define OFS_TOP_STATUS    6'h20
`define OFS_TOP_DISABLE   6'h24
`define OFS_AUX_CONFIG    6'h28

// ----------------------------------------------------------------------------
// main status / disable bit positions
// ----------------------------------------------------------------------------
`define MS_TIMER2         0
`define MS_TIMER1         1
`define MS_PEER           2
`define MS_CODE           3
`define MS_EXT            4
`define MS_MON            5
`define MS_WIDTH          6

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define EXT_RESEND        0
`define EXT_UNDERRUN      1
`define FEAT_CH1_EN       0
`define FEAT_TERMINAL     1
`define FEAT_AUTO         2
`define CODE_W            4
`define CODE_CH0_BIT      4
`define CODE_CH1_BIT      5
`define TOP_SIG_BIT       2
`define MAIN_DISABLE_RST  6'h00
`define TOP_DISABLE_RST   2'h3
`define FEATURE_RST       3'h0
`define MON_CTRL_RST      6'h00
`define AUX_CONFIG_RST    6'h00

`endif

// ---- dchan_pkg.sv ----
`default_nettype none

package dchan_pkg;

  // --------------------------------------------------------------------------
  // signalling-channel events from the layer-2 core, one-cycle pulses
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic tx_error;
    logic neg_ack;
    logic fifo_empty;
    logic eom_given;
    logic peer_sup_frame;
    logic ext_timer;
    logic retx_timer;
    logic retry_done;
    logic timer2;
  } sig_ev_t;

  // --------------------------------------------------------------------------
  // one monitor channel as seen from the serial highway
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       tx_ind;
    logic [7:0] data;
    logic       end_rx;
    logic       acked;
    logic       aborted;
  } mon_in_t;

  typedef struct packed {
    logic mab;
    logic mda;
    logic mer;
    logic mdr;
  } mon_st_t;

  typedef struct packed {
    logic mie;
    logic mrc;
    logic mre;
  } mon_ctl_t;

endpackage

`default_nettype wire

// ---- code_buf.sv ----
`include "dchan_defines.svh"
`default_nettype none

// two-deep received code buffer: held code plus the latest pending change
module code_buf (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // code input and host read
  input  wire logic [`CODE_W-1:0]   code_in,
  input  wire logic                 rd,
  // held code and load event
  output logic      [`CODE_W-1:0]   code_q,
  output logic                      new_q
);

  logic [`CODE_W-1:0] seen_q;
  logic [`CODE_W-1:0] pend_q;
  logic               pend_v_q;
  logic               unread_q;
  logic               change;

  assign change = code_in != seen_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_q   <= '0;
      pend_q   <= '0;
      pend_v_q <= 1'b0;
      unread_q <= 1'b0;
      code_q   <= '0;
      new_q    <= 1'b0;
    end else begin
      seen_q <= code_in;
      new_q  <= 1'b0;
      if (rd && (pend_v_q || change)) begin
        // later changes overwrite the pending slot, so only the last survives
        code_q   <= change ? code_in : pend_q;
        new_q    <= 1'b1;
        unread_q <= 1'b1;
        pend_v_q <= 1'b0;
      end else if (rd) begin
        unread_q <= 1'b0;
      end else if (change && unread_q) begin
        pend_q   <= code_in;
        pend_v_q <= 1'b1;
      end else if (change) begin
        code_q   <= code_in;
        new_q    <= 1'b1;
        unread_q <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- dchan_cmon_aux_irq_logic.sv ----
// Behaviour
// - set resend flag on error or auto negative ack
// - underrun aborts frame, sets underrun flag
// - auto mode: peer RR/RNR sets change flag
// - first timer: external, or auto retransmit+retry expiry
// - second timer flag per expiry, no acknowledge
// - code change ch0; ch1 only terminal mode
// - ch1 change hidden until enable bit set
// - reading code register 0 clears both bits
// - status on every new code load
// - hold change until read, then load immediately
// - two-deep code buffer: first then last
// - non-terminal mode: only monitor channel 0
// - ch0 gating: data/end by rx+handshake, rest shared
// - ch0 data-received gated by enable and handshake
// - ch1 gating: data by rx+handshake, rest shared
// - ch1 data-received same gating; handshake bit drives receive handshake
// - aux pins as I/O, input interrupts maskable
// - aux interrupt on falling edge or low level
// - aux interrupts masked after reset, others not
// - main status timer/peer bits clear on read; code change, ext and mon bits do not
// - masked bits hidden except code change, kept pending across reads
// - code change set even when masked, no interrupt
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`include "dchan_defines.svh"
`default_nettype none

module dchan_cmon_aux_irq_logic (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // avalon-mm slave
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // layer-2 core events
  input  wire dchan_pkg::sig_ev_t          sig_ev,
  output logic                             tx_abort,
  // command/indication codes
  input  wire logic [`CODE_W-1:0]          code_in_0,
  input  wire logic [`CODE_W-1:0]          code_in_1,
  // monitor channels
  input  wire dchan_pkg::mon_in_t [1:0]    mon_in,
  output logic      [1:0]                  mon_rx_handshake_ctl,
  // auxiliary pins
  input  wire logic [1:0]                  aux_in,
  output logic      [1:0]                  aux_out,
  output logic      [1:0]                  aux_oe,
  // host interrupt
  output logic                             irq
);

  // --------------------------------------------------------------------------
  // bus slave: one wait state, access takes effect when waitrequest is low
  // --------------------------------------------------------------------------
  logic                     acc;
  logic                     rd_acc;
  logic                     wr_acc;
  logic [31:0]              rdata_d;

  assign acc    = (avs_read || avs_write) && !avs_waitrequest;
  assign rd_acc = acc && avs_read;
  assign wr_acc = acc && avs_write;

  function automatic logic hit(input logic [5:0] ofs, input logic [5:0] a);
    hit = {a[5:2], 2'b00} == ofs;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  logic [`MS_WIDTH-1:0]     main_dis_q;
  logic [1:0]               top_dis_q;
  logic [2:0]               feature_q;
  dchan_pkg::mon_ctl_t [1:0] mon_ctl_q;
  logic [5:0]               aux_cfg_q;
  logic                     auto_mode;
  logic                     terminal;
  logic                     ch1_en;

  assign auto_mode = feature_q[`FEAT_AUTO];
  assign terminal  = feature_q[`FEAT_TERMINAL];
  assign ch1_en    = feature_q[`FEAT_CH1_EN];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_dis_q <= `MAIN_DISABLE_RST;
      top_dis_q  <= `TOP_DISABLE_RST;
      feature_q  <= `FEATURE_RST;
      mon_ctl_q  <= `MON_CTRL_RST;
      aux_cfg_q  <= `AUX_CONFIG_RST;
    end else if (wr_acc) begin
      if (hit(`OFS_MAIN_DISABLE, avs_address)) main_dis_q <= avs_writedata[`MS_WIDTH-1:0];
      if (hit(`OFS_TOP_DISABLE, avs_address))  top_dis_q  <= avs_writedata[1:0];
      if (hit(`OFS_FEATURE_1, avs_address))    feature_q  <= avs_writedata[2:0];
      if (hit(`OFS_MON_CTRL, avs_address))     mon_ctl_q  <= avs_writedata[5:0];
      if (hit(`OFS_AUX_CONFIG, avs_address))   aux_cfg_q  <= avs_writedata[5:0];
    end
  end

  // --------------------------------------------------------------------------
  // signalling channel events
  // --------------------------------------------------------------------------
  logic [1:0]               ext_q;
  logic [2:0]               sig_st_q;
  logic [1:0]               ext_set;
  logic [2:0]               sig_set;
  logic [`MS_WIDTH-1:0]     main_raw;
  logic [`MS_WIDTH-1:0]     main_vis;
  logic                     rd_main;
  logic                     rd_ext;
  logic                     underrun;

  assign underrun = sig_ev.fifo_empty && !sig_ev.eom_given;
  assign ext_set[`EXT_RESEND]   = sig_ev.tx_error || (auto_mode && sig_ev.neg_ack);
  assign ext_set[`EXT_UNDERRUN] = underrun;
  assign sig_set[`MS_TIMER2]    = sig_ev.timer2;
  assign sig_set[`MS_TIMER1]    = auto_mode ? (sig_ev.retx_timer && sig_ev.retry_done)
                                            : sig_ev.ext_timer;
  assign sig_set[`MS_PEER]      = auto_mode && sig_ev.peer_sup_frame;
  assign rd_main = rd_acc && hit(`OFS_MAIN_STATUS, avs_address);
  assign rd_ext  = rd_acc && hit(`OFS_EXT_STATUS, avs_address);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_q    <= '0;
      tx_abort <= 1'b0;
    end else begin
      ext_q    <= (rd_ext ? (ext_q & ~avs_readdata[1:0]) : ext_q) | ext_set;
      tx_abort <= underrun;
    end
  end

  // only bits that the read showed are cleared; masked ones stay pending
  // the shown copy sits in readdata, so a bit set during the wait state survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sig_st_q <= '0;
    end else begin
      sig_st_q <= (sig_st_q & ~(rd_main ? avs_readdata[2:0] : 3'h0)) | sig_set;
    end
  end

  // --------------------------------------------------------------------------
  // command/indication code change
  // --------------------------------------------------------------------------
  logic [`CODE_W-1:0]       code0_q;
  logic [`CODE_W-1:0]       code1_q;
  logic                     new0;
  logic                     new1;
  logic                     rd_code0;
  logic                     rd_code1;
  logic                     chg0_q;
  logic                     chg1_raw_q;
  logic                     chg1_vis;

  assign rd_code0 = rd_acc && hit(`OFS_CODE_RX_0, avs_address);
  assign rd_code1 = rd_acc && hit(`OFS_CODE_RX_1, avs_address);
  assign chg1_vis = chg1_raw_q && ch1_en;

  code_buf u_code0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .code_in (code_in_0),
    .rd      (rd_code0),
    .code_q  (code0_q),
    .new_q   (new0)
  );

  code_buf u_code1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .code_in (code_in_1),
    .rd      (rd_code1),
    .code_q  (code1_q),
    .new_q   (new1)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chg0_q     <= 1'b0;
      chg1_raw_q <= 1'b0;
    end else begin
      chg0_q     <= (chg0_q && !rd_code0) || new0;
      chg1_raw_q <= (chg1_raw_q && !rd_code0) || (new1 && terminal);
    end
  end

  // --------------------------------------------------------------------------
  // monitor channels
  // --------------------------------------------------------------------------
  dchan_pkg::mon_st_t [1:0] mon_st_q;
  logic [1:0][7:0]          mon_data_q;
  logic [1:0]               tx_ind_q;
  logic [1:0]               in_pkt_q;
  logic                     rd_mon;

  assign rd_mon = rd_acc && hit(`OFS_MON_STATUS, avs_address);

  for (genvar c = 0; c < 2; c++) begin : g_mon
    logic               live;
    logic               byte_rx;
    logic               mdr_set;
    logic               mer_en;
    dchan_pkg::mon_st_t set;

    // channel 1 only runs in terminal mode
    assign live    = (c == 0) || terminal;
    assign byte_rx = live && tx_ind_q[c] && !mon_in[c].tx_ind;
    assign mdr_set = byte_rx && mon_ctl_q[c].mre && (mon_ctl_q[c].mrc || !in_pkt_q[c]);
    assign mer_en  = (c == 0) ? (mon_ctl_q[c].mre && mon_ctl_q[c].mrc) : mon_ctl_q[c].mie;
    assign set.mdr = mdr_set;
    assign set.mer = live && mon_in[c].end_rx && mer_en;
    assign set.mda = live && mon_in[c].acked && mon_ctl_q[c].mie;
    assign set.mab = live && mon_in[c].aborted && mon_ctl_q[c].mie;

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        mon_st_q[c]   <= '0;
        mon_data_q[c] <= 8'h00;
        tx_ind_q[c]   <= 1'b1;
        in_pkt_q[c]   <= 1'b0;
      end else begin
        tx_ind_q[c] <= mon_in[c].tx_ind;
        mon_st_q[c] <= (rd_mon ? (mon_st_q[c] & ~avs_readdata[4*c +: 4]) : mon_st_q[c]) | set;
        if (mdr_set) begin
          mon_data_q[c] <= mon_in[c].data;
        end
        if (mon_in[c].end_rx || mon_in[c].aborted) begin
          in_pkt_q[c] <= 1'b0;
        end else if (byte_rx) begin
          in_pkt_q[c] <= 1'b1;
        end
      end
    end
  end

  // the handshake bit is only driven while handshake control is on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_rx_handshake_ctl <= 2'h0;
    end else begin
      mon_rx_handshake_ctl <= {mon_ctl_q[1].mrc && terminal, mon_ctl_q[0].mrc};
    end
  end

  // --------------------------------------------------------------------------
  // auxiliary pins
  // --------------------------------------------------------------------------
  logic [1:0]               aux_prev_q;
  logic [1:0]               top_st_q;
  logic [1:0]               aux_set;
  logic                     rd_top;

  assign rd_top = rd_acc && hit(`OFS_TOP_STATUS, avs_address);

  // edge mode when the select bit is 0, low level when 1
  assign aux_set = ~aux_cfg_q[3:2] & ((aux_prev_q & ~aux_in & ~aux_cfg_q[1:0])
                                     | (~aux_in & aux_cfg_q[1:0]));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_prev_q <= 2'h3;
      top_st_q   <= 2'h0;
      aux_out    <= 2'h0;
      aux_oe     <= 2'h0;
    end else begin
      aux_prev_q <= aux_in;
      top_st_q   <= (rd_top ? (top_st_q & ~avs_readdata[1:0]) : top_st_q) | aux_set;
      aux_out    <= aux_cfg_q[5:4];
      aux_oe     <= aux_cfg_q[3:2];
    end
  end

  // --------------------------------------------------------------------------
  // status views and interrupt
  // --------------------------------------------------------------------------
  logic                     sig_pend;

  always_comb begin
    main_raw                = '0;
    main_raw[2:0]           = sig_st_q;
    main_raw[`MS_CODE]      = chg0_q || chg1_vis;
    main_raw[`MS_EXT]       = |ext_q;
    main_raw[`MS_MON]       = |mon_st_q;
    main_vis                = main_raw & ~main_dis_q;
    main_vis[`MS_CODE]      = main_raw[`MS_CODE];
  end

  assign sig_pend = |(main_raw & ~main_dis_q);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= sig_pend || |(top_st_q & ~top_dis_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case ({avs_address[5:2], 2'b00})
      `OFS_MAIN_STATUS:  rdata_d[`MS_WIDTH-1:0] = main_vis;
      `OFS_MAIN_DISABLE: rdata_d[`MS_WIDTH-1:0] = main_dis_q;
      `OFS_EXT_STATUS:   rdata_d[1:0] = ext_q;
      `OFS_CODE_RX_0:    rdata_d[5:0] = {chg1_vis, chg0_q, code0_q};
      `OFS_CODE_RX_1:    rdata_d[`CODE_W-1:0] = code1_q;
      `OFS_FEATURE_1:    rdata_d[2:0] = feature_q;
      `OFS_MON_CTRL:     rdata_d[5:0] = mon_ctl_q;
      `OFS_MON_STATUS:   rdata_d = {mon_data_q[1], mon_data_q[0], 8'h00, mon_st_q};
      `OFS_TOP_STATUS:   rdata_d[2:0] = {sig_pend, top_st_q & ~top_dis_q};
      `OFS_TOP_DISABLE:  rdata_d[1:0] = top_dis_q;
      `OFS_AUX_CONFIG:   rdata_d[5:0] = aux_cfg_q;
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  a_resend_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sig_ev.tx_error || (auto_mode && sig_ev.neg_ack)) |=> ext_q[`EXT_RESEND])
    else $error("resend flag not set");

  a_underrun_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    underrun |=> tx_abort && ext_q[`EXT_UNDERRUN])
    else $error("underrun did not abort and flag");

  a_peer_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !auto_mode && sig_ev.peer_sup_frame && !sig_st_q[`MS_PEER] |=> !sig_st_q[`MS_PEER])
    else $error("peer change flagged outside auto mode");

  a_timer_auto: assert property (@(posedge clk_sys) disable iff (!rst_n)
    auto_mode && sig_ev.ext_timer && !(sig_ev.retx_timer && sig_ev.retry_done)
      && !sig_st_q[`MS_TIMER1] |=> !sig_st_q[`MS_TIMER1])
    else $error("external timer raised first timer flag in auto mode");

  a_timer2_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sig_ev.timer2 |=> sig_st_q[`MS_TIMER2])
    else $error("second timer flag missing");

  a_code_clear_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_code0 && !new0 && !new1 |=> !chg0_q && !chg1_raw_q)
    else $error("code change bits not cleared by read");

  a_mdr_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mon_ctl_q[0].mre && !mon_st_q[0].mdr ##1 !rd_mon |-> !mon_st_q[0].mdr)
    else $error("data received flagged while receive disabled");

  a_aux_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    aux_prev_q[0] && !aux_in[0] && !aux_cfg_q[2] |=> top_st_q[0])
    else $error("aux falling edge not latched");

  a_aux_mask_rst: assert property (@(posedge clk_sys)
    !rst_n |=> top_dis_q == 2'h3 [*2])
    else $error("aux interrupts not masked after reset");

  a_irq_pending: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sig_pend || |(top_st_q & ~top_dis_q)) |=> irq)
    else $error("interrupt not raised for pending status");

  a_code_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    main_raw[`MS_CODE] && main_dis_q[`MS_CODE] && sig_st_q == 3'h0 && ext_q == 2'h0
      && mon_st_q == '0 && (top_st_q & ~top_dis_q) == 2'h0 |=> !irq)
    else $error("masked code change misbehaved");

endmodule

`default_nettype wire

// ---- host_model.sv ----
`default_nettype none

// avalon-mm master standing in for the host processor
module host_model (
  // bus
  input  wire logic        clk_sys,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // request stays put until waitrequest is seen low; no latency is assumed
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= wd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- tb_dchan_cmon_aux_irq_logic.sv ----
`include "dchan_defines.svh"
`default_nettype none

module tb_dchan_cmon_aux_irq_logic;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     clk_sys = 1'b0;
  logic                     rst_n;
  logic [5:0]               avs_address;
  logic                     avs_read;
  logic                     avs_write;
  logic [31:0]              avs_writedata;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  dchan_pkg::sig_ev_t       sig_ev;
  logic                     tx_abort;
  logic [`CODE_W-1:0]       code_in_0;
  logic [`CODE_W-1:0]       code_in_1;
  dchan_pkg::mon_in_t [1:0] mon_in;
  logic [1:0]               mon_rx_handshake_ctl;
  logic [1:0]               aux_in;
  logic [1:0]               aux_out;
  logic [1:0]               aux_oe;
  logic                     irq;
  int                       error_cnt = 0;
  int                       n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  dchan_cmon_aux_irq_logic dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .sig_ev, .tx_abort, .code_in_0, .code_in_1, .mon_in,
    .mon_rx_handshake_ctl, .aux_in, .aux_out, .aux_oe, .irq);
  host_model h (.clk_sys, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m = '1);
    n_compared++;
    if ((got & m) !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    h.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] x;
    h.xfer(1'b0, a, 32'h0, x);
    chk(x, e, m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic ev(input logic [8:0] v);
    @(posedge clk_sys);
    sig_ev <= dchan_pkg::sig_ev_t'(v);
    @(posedge clk_sys);
    sig_ev <= '0;
  endtask

  // aux pins idle high, so a pulse low is one falling edge
  task automatic apulse(input logic [1:0] v);
    @(posedge clk_sys);
    aux_in <= v;
    @(posedge clk_sys);
    aux_in <= 2'h3;
    cyc(3);
  endtask

  // a byte is marked by the transmit indication going from 1 to 0
  task automatic mbyte(input logic [7:0] d);
    @(posedge clk_sys);
    mon_in[0].data <= d;
    mon_in[0].tx_ind <= 1'b0;
    cyc(2);
    mon_in[0].tx_ind <= 1'b1;
    cyc(3);
  endtask

  task automatic results;
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    sig_ev = '0;
    code_in_0 = 4'h0;
    code_in_1 = 4'h0;
    mon_in = '0;
    mon_in[0].tx_ind = 1'b1;
    mon_in[1].tx_ind = 1'b1;
    aux_in = 2'h3;
    cyc(3);
    rst_n <= 1'b1;
    rd(`OFS_MAIN_DISABLE, 32'h0);
    rd(`OFS_TOP_DISABLE, 32'h3);
    rd(6'h3c, 32'h0);
    ev(9'h001);
    cyc(2);
    chk(32'(irq), 32'h1);
    rd(`OFS_MAIN_STATUS, 32'h1 << `MS_TIMER2);
    rd(`OFS_MAIN_STATUS, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(`OFS_MAIN_DISABLE, 32'h1 << `MS_TIMER1);
    ev(9'h008);
    rd(`OFS_MAIN_STATUS, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(`OFS_MAIN_DISABLE, 32'h0);
    rd(`OFS_MAIN_STATUS, 32'h1 << `MS_TIMER1);
    ev(9'h016);
    rd(`OFS_MAIN_STATUS, 32'h0);
    wr(`OFS_FEATURE_1, 32'h1 << `FEAT_AUTO);
    ev(9'h010);
    ev(9'h00c);
    rd(`OFS_MAIN_STATUS, 32'h1 << `MS_PEER);
    ev(9'h006);
    rd(`OFS_MAIN_STATUS, 32'h1 << `MS_TIMER1);
    wr(`OFS_TOP_DISABLE, 32'h0);
    apulse(2'h2);
    rd(`OFS_TOP_STATUS, 32'h1, 32'h3);
    rd(`OFS_TOP_STATUS, 32'h0, 32'h3);
    wr(`OFS_AUX_CONFIG, 32'h2);
    aux_in <= 2'h1;
    cyc(3);
    rd(`OFS_TOP_STATUS, 32'h2, 32'h3);
    rd(`OFS_TOP_STATUS, 32'h2, 32'h3);
    aux_in <= 2'h3;
    wr(`OFS_TOP_DISABLE, 32'h3);
    apulse(2'h2);
    rd(`OFS_TOP_STATUS, 32'h0, 32'h3);
    wr(`OFS_AUX_CONFIG, 32'h14);
    cyc(2);
    chk({aux_oe, aux_out}, 32'h5);
    rd(`OFS_CODE_RX_0, 32'h0);
    rd(`OFS_CODE_RX_1, 32'h0);
    code_in_0 <= 4'h5;
    cyc(3);
    code_in_0 <= 4'h6;
    cyc(1);
    code_in_0 <= 4'h9;
    cyc(3);
    rd(`OFS_CODE_RX_0, 32'h15);
    rd(`OFS_CODE_RX_0, 32'h19);
    rd(`OFS_CODE_RX_0, 32'h09);
    wr(`OFS_FEATURE_1, 32'h3);
    code_in_1 <= 4'h7;
    cyc(4);
    rd(`OFS_CODE_RX_0, 32'h29);
    rd(`OFS_CODE_RX_1, 32'h7);
    wr(`OFS_FEATURE_1, 32'h2);
    code_in_1 <= 4'h3;
    cyc(4);
    rd(`OFS_MAIN_STATUS, 32'h0);
    wr(`OFS_FEATURE_1, 32'h3);
    rd(`OFS_CODE_RX_0, 32'h29);
    rd(`OFS_CODE_RX_1, 32'h3);
    wr(`OFS_MAIN_DISABLE, 32'h1 << `MS_CODE);
    code_in_0 <= 4'h2;
    cyc(4);
    rd(`OFS_MAIN_STATUS, 32'h1 << `MS_CODE);
    chk(32'(irq), 32'h0);
    rd(`OFS_CODE_RX_0, 32'h12);
    wr(`OFS_MAIN_DISABLE, 32'h0);
    wr(`OFS_MON_CTRL, 32'h0);
    mbyte(8'ha5);
    rd(`OFS_MON_STATUS, 32'h0, 32'h1);
    wr(`OFS_MON_CTRL, 32'h3);
    cyc(2);
    chk(32'(mon_rx_handshake_ctl[0]), 32'h1);
    mbyte(8'h3c);
    rd(`OFS_MON_STATUS, 32'h003c0001, 32'h00ff0001);
    wr(`OFS_MON_CTRL, 32'h1);
    mbyte(8'h11);
    rd(`OFS_MON_STATUS, 32'h0, 32'h1);
    @(posedge clk_sys) mon_in[0].end_rx <= 1'b1;
    @(posedge clk_sys) mon_in[0].end_rx <= 1'b0;
    mbyte(8'h22);
    rd(`OFS_MON_STATUS, 32'h00220001, 32'h00ff0001);
    ev(9'h100);
    ev(9'h040);
    @(posedge clk_sys);
    chk(32'(tx_abort), 32'h1);
    rd(`OFS_EXT_STATUS, 32'h3);
    ev(9'h060);
    rd(`OFS_EXT_STATUS, 32'h0);
    wr(`OFS_FEATURE_1, 32'h1 << `FEAT_AUTO);
    ev(9'h080);
    rd(`OFS_EXT_STATUS, 32'h1);
    results();
  end

  initial begin
    #100us;
    error_cnt++;
    results();
  end
endmodule

`default_nettype wire
